// >>> include/vpmr_pkg.sv
// package for the preset register bank: offsets, reset values, field layout
// assumes the serial protocol engine and the converter use the same sys_clk
package vpmr_pkg;
    localparam int NUM_PRESETS = 4;
    localparam int PTR_W = 8;
    localparam int SEL_W = 2;
    localparam int CODE_W = 6;
    localparam int DATA_W = 8;

    // register pointers of the four presets
    localparam logic [PTR_W-1:0] OFF_PRESET_LOW_LOW = 8'h00;
    localparam logic [PTR_W-1:0] OFF_PRESET_LOW_HIGH = 8'h01;
    localparam logic [PTR_W-1:0] OFF_PRESET_HIGH_LOW = 8'h02;
    localparam logic [PTR_W-1:0] OFF_PRESET_HIGH_HIGH = 8'h03;
    localparam logic [PTR_W-1:0] PTR_STEP = 8'h01;
    localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;

    // reset values, index 0 is the lowest pointer
    localparam logic [NUM_PRESETS-1:0][DATA_W-1:0] PRESET_RESET =
        {8'h9E, 8'hB0, 8'h1E, 8'hB4};
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // voltage code scale
    localparam int CODE_BASE_MV = 750;
    localparam int CODE_STEP_MV = 10;

    // preset field layout: bit 7 forced pwm, bit 6 external lock, bits 5..0 code
    typedef struct packed {
        logic forcedPwm;
        logic extClockLock;
        logic [CODE_W-1:0] voltageCode;
    } vpmr_preset_s;

    // byte-level access from the serial protocol engine
    typedef struct packed {
        logic ptrLoad;
        logic wrStrobe;
        logic rdStrobe;
        logic [DATA_W-1:0] data;
    } vpmr_access_s;
endpackage : vpmr_pkg

// >>> core/vpmr_preset_bank.sv
// preset register bank with voltage-select and undervoltage handling
// assumes a protocol engine on sys_clk that gives one strobe per byte,
// the write strobe falling in the cycle the data byte is acknowledged
// What this block does
// - both select pins low use preset zero
// - pin b low, pin a high: preset one
// - pin b high, pin a low: preset two
// - bit 7 forces pwm, else automatic mode
// - bit 6 enables lock to external clock
// - bits 5..0 code, 0.75 V plus 10 mV
// - active preset write takes effect at acknowledge
// - both pins high use preset three
// - pointer advances after every data byte
`timescale 1ns/1ps
module vpmr_preset_bank (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire vpmr_pkg::vpmr_access_s access,
    input wire logic voltageSelectPinA,
    input wire logic voltageSelectPinB,
    input wire logic logicSupplyUndervoltage,
    input wire logic mainInputSupplyUndervoltage,
    output logic [vpmr_pkg::DATA_W-1:0] readData,
    output logic forcedPwm,
    output logic extClockLock,
    output logic [vpmr_pkg::CODE_W-1:0] voltageCode
);
    logic [vpmr_pkg::SEL_W-1:0] selSync1_r;
    logic [vpmr_pkg::SEL_W-1:0] selSync2_r;
    logic [1:0] uvSync1_r;
    logic [1:0] uvSync2_r;
    logic uvloActive;
    logic [vpmr_pkg::PTR_W-1:0] ptr_r;
    logic [vpmr_pkg::PTR_W-1:0] ptr_nxt;
    logic [vpmr_pkg::DATA_W-1:0] readData_r;
    logic [vpmr_pkg::DATA_W-1:0] readData_nxt;
    vpmr_pkg::vpmr_preset_s preset_r [vpmr_pkg::NUM_PRESETS];
    vpmr_pkg::vpmr_preset_s preset_nxt [vpmr_pkg::NUM_PRESETS];
    vpmr_pkg::vpmr_preset_s active_r;
    vpmr_pkg::vpmr_preset_s active_nxt;
    logic ptrMapped;

    // pins and supply monitors are asynchronous: two flops before use
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            selSync1_r <= 2'h0;
            selSync2_r <= 2'h0;
            uvSync1_r <= 2'h0;
            uvSync2_r <= 2'h0;
        end
        else
        begin
            selSync1_r <= {voltageSelectPinB, voltageSelectPinA};
            selSync2_r <= selSync1_r;
            uvSync1_r <= {mainInputSupplyUndervoltage, logicSupplyUndervoltage};
            uvSync2_r <= uvSync1_r;
        end
    end

    assign uvloActive = |uvSync2_r;
    assign ptrMapped = (ptr_r <= vpmr_pkg::OFF_PRESET_HIGH_HIGH);

    // one register per preset; unmapped pointers are acknowledged but ignored
    genvar i;
    generate
        for (i = 0; i < vpmr_pkg::NUM_PRESETS; i++)
        begin : gPreset
            always_comb
            begin
                preset_nxt[i] = preset_r[i];
                if (uvloActive)
                    preset_nxt[i] = vpmr_pkg::PRESET_RESET[i];
                else if (access.wrStrobe && !access.ptrLoad &&
                         ptr_r == vpmr_pkg::PTR_W'(i))
                    preset_nxt[i] = access.data;
            end

            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                    preset_r[i] <= vpmr_pkg::PRESET_RESET[i];
                else
                    preset_r[i] <= preset_nxt[i];
            end
        end
    endgenerate

    // pointer load, then auto-increment after each data byte
    always_comb
    begin
        ptr_nxt = ptr_r;
        readData_nxt = readData_r;
        if (access.ptrLoad)
            ptr_nxt = access.data;
        else if (access.wrStrobe || access.rdStrobe)
            ptr_nxt = ptr_r + vpmr_pkg::PTR_STEP;
        if (access.rdStrobe && !access.ptrLoad)
            readData_nxt = ptrMapped ? preset_r[ptr_r[vpmr_pkg::SEL_W-1:0]]
                                     : vpmr_pkg::UNMAPPED_READ;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ptr_r <= vpmr_pkg::PTR_RESET;
            readData_r <= vpmr_pkg::UNMAPPED_READ;
        end
        else
        begin
            ptr_r <= ptr_nxt;
            readData_r <= readData_nxt;
        end
    end

    // active settings follow the next preset value, so a write to the
    // selected preset lands in the same edge as the register itself
    always_comb
    begin
        active_nxt = preset_nxt[selSync2_r];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            active_r <= vpmr_pkg::PRESET_RESET[0];
        else
            active_r <= active_nxt;
    end

    assign readData = readData_r;
    assign forcedPwm = active_r.forcedPwm;
    assign extClockLock = active_r.extClockLock;
    assign voltageCode = active_r.voltageCode;
endmodule : vpmr_preset_bank

// >>> verification/vpmr_props.sv
// port checker for the preset bank
// assumes it is bound onto vpmr_preset_bank
`timescale 1ns/1ps
module vpmr_props (
    input wire logic sys_clk, rst_n, voltageSelectPinA, voltageSelectPinB,
    input wire vpmr_pkg::vpmr_access_s access,
    input wire logic logicSupplyUndervoltage, mainInputSupplyUndervoltage,
    input wire logic [7:0] readData,
    input wire logic forcedPwm, extClockLock,
    input wire logic [5:0] voltageCode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // selected pins and active byte
    wire logic [1:0] sel = {voltageSelectPinB, voltageSelectPinA};
    wire logic [7:0] act = {forcedPwm, extClockLock, voltageCode};
    wire logic uv = logicSupplyUndervoltage || mainInputSupplyUndervoltage;
    read_hold_a:
        assert property (!access.rdStrobe |=> $stable(readData)) else $error("read moved");
    uv_low_a:
        assert property ((logicSupplyUndervoltage && sel == 2'h0)[*5] |-> act == 8'hB4)
        else $error("bad default 0");
    uv_high_a:
        assert property ((mainInputSupplyUndervoltage && sel == 2'h3)[*5] |-> act == 8'h9E)
        else $error("bad default 3");
    uv_pin_a_a:
        assert property ((mainInputSupplyUndervoltage && sel == 2'h1)[*5] |-> act == 8'h1E)
        else $error("bad default 1");
    uv_pin_b_a:
        assert property ((logicSupplyUndervoltage && sel == 2'h2)[*5] |-> act == 8'hB0)
        else $error("bad default 2");
    // six quiet cycles cover sync latency
    idle_hold_a:
        assert property ((!access.wrStrobe && !uv && $stable(sel))[*6] |=> $stable(act))
        else $error("active moved");
    cover property (access.wrStrobe && sel == 2'h2);
    cover property (logicSupplyUndervoltage[*5]);
    cover property (access.rdStrobe ##1 access.ptrLoad);
endmodule : vpmr_props
bind vpmr_preset_bank vpmr_props i_vpmr_props (.*);

// >>> verification/vpmr_host_model.sv
// host side: one byte strobe per call
// assumes sys_clk from the bench
`timescale 1ns/1ps
module vpmr_host_model (
    input wire logic sys_clk,
    output vpmr_pkg::vpmr_access_s access
);
    initial access = '0;
    // data inverted once released, never left stale
    task automatic send(input logic [2:0] kind, input logic [7:0] d);
    begin
        @(posedge sys_clk) #1 access = {kind, d};
        @(posedge sys_clk) #1 access = {3'h0, ~d};
    end
    endtask : send
endmodule : vpmr_host_model

// >>> verification/vid_preset_mode_registers_tb_top.sv
// bench for the preset bank against an integer model
// assumes the host model and checker files compile first
`timescale 1ns/1ps
module vid_preset_mode_registers_tb_top;
    logic sys_clk = 0, rst_n = 0, pinA = 0, pinB = 0, uvLogic = 0, uvMain = 0;
    logic [7:0] readData, d;
    logic [5:0] voltageCode;
    logic forcedPwm, extClockLock;
    vpmr_pkg::vpmr_access_s access;
    wire logic [7:0] act = {forcedPwm, extClockLock, voltageCode};
    int mdl[4] = '{8'hB4, 8'h1E, 8'hB0, 8'h9E};
    int error_cnt = 0, checked = 0, i, j, seed = 32'h23DF05CE;
    vpmr_host_model i_host (.sys_clk(sys_clk), .access(access));
    vpmr_preset_bank i_vpmr_preset_bank (.sys_clk(sys_clk), .rst_n(rst_n), .access(access),
        .voltageSelectPinA(pinA), .voltageSelectPinB(pinB), .logicSupplyUndervoltage(uvLogic),
        .mainInputSupplyUndervoltage(uvMain), .readData(readData), .forcedPwm(forcedPwm),
        .extClockLock(extClockLock), .voltageCode(voltageCode));
    // 50 MHz
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic cmp(input logic [7:0] got, input int exp);
    begin
        checked++;
        if (got !== exp[7:0])
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp[7:0]);
        end
    end
    endtask : cmp
    // pointer zero, five bytes, fifth is unmapped
    task automatic blk(input bit wr);
    begin
        i_host.send(3'b100, 8'h00);
        for (int k = 0; k < 5; k++)
        begin
            d = $random(seed);
            i_host.send(wr ? 3'b010 : 3'b001, d);
            if (wr && k < 4) mdl[k] = d;
            if (!wr) cmp(readData, k < 4 ? mdl[k] : 0);
        end
        $display("block %0d done", wr);
    end
    endtask : blk
    // three sync edges plus one spare
    task automatic pick(input int s);
    begin
        @(posedge sys_clk) #1 {pinB, pinA} = s[1:0];
        repeat (4) @(posedge sys_clk);
        #1 cmp(act, mdl[s]);
    end
    endtask : pick
    task automatic complete_run;
    begin
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask : complete_run
    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1;
        blk(0);
        blk(1);
        blk(0);
        for (i = 0; i < 4; i++)
        begin
            pick(i);
            d = $random(seed);
            i_host.send(3'b100, i[7:0]);
            i_host.send(3'b010, d);
            mdl[i] = d;
            cmp(act, d);
        end
        // every select setting under alternating supply faults
        for (j = 0; j < 4; j++)
        begin
            blk(1);
            pick(j);
            @(posedge sys_clk) #1 {uvMain, uvLogic} = (j % 2) ? 2'b10 : 2'b01;
            repeat (6) @(posedge sys_clk);
            #1 {uvMain, uvLogic} = 2'b00;
            mdl = '{8'hB4, 8'h1E, 8'hB0, 8'h9E};
            blk(0);
            pick(j);
        end
        complete_run();
    end
    // hang guard, far beyond the sequence
    initial
    begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : vid_preset_mode_registers_tb_top
